// File: cir_config_index_regs.sv
// Behaviour
// [R1] Index written to 22H, data at 23H
// [R2] Software rewrites index before each access
// [R3] Data access consumes index; stale access ignored
// [R4] Port B bits 5,4 read-only status
// [R5] Port B bits 3,2 check enables
// [R6] Port B bits 1,0 speaker data, gate
// [R7] Index 04H version read-only, bit 5 reserved
// [R8] Bit 4 selects processor clock source
// [R9] Software avoids illegal clock source pairing
// [R10] Bit 3 enables power-fail NMI
// [R11] Bit 2 enables ready-timeout NMI
// [R12] Bit 1 reports power-fail at arbitration
// [R13] Bit 0 reports ready timeout occurred
// [R14] Timeout after 128 cycles without ready
// [R15] Command delay field equals cycle count
// [R16] 05H wide, half memory delays reset 0
// [R17] 05H byte memory, I/O delays reset 1
// [R18] Delay postpones strobes in half-clock steps
// [R19] 32-bit wait codes give 3..0 waits
// [R20] 16-bit wait codes give 3..0 waits
// [R21] 8-bit wait codes give 5..2 waits
// [R22] Bits 1:0 of 06H select bus clock
// [R23] Port B needs chip-select; bits 7,6 status
// [R24] Reserved bits read zero, writes ignored
// [R25] Full reset loads defaults; warm reset keeps
`timescale 1ns/100ps
`include "cir_map.svh"

module cir_config_index_regs
  import cir_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cpu_warm_rst,
  input  wire logic [15:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  output logic            io_rdata_valid,
  input  wire logic       speaker_port_select,
  input  wire logic       peripheral_io_read,
  input  wire logic       peripheral_io_write,
  input  wire logic       cycle_start_strobe,
  input  wire logic       local_bus_claim,
  input  wire logic       ready_in,
  input  wire logic       power_fail_input,
  input  wire logic       timer_two_output_status,
  input  wire logic       refresh_detect_status,
  input  wire logic       parity_error_status,
  input  wire logic       channel_error_status,
  output logic            proc_clock_select,
  output logic            power_fail_nmi_enable,
  output logic            ready_timeout_nmi_enable,
  output logic            power_fail_seen_flag,
  output logic            ready_timeout_flag,
  output logic            nmi_out,
  output logic      [1:0] wide_mem_cmd_delay,
  output logic      [1:0] half_mem_cmd_delay,
  output logic      [1:0] byte_mem_cmd_delay,
  output logic      [1:0] io_cmd_delay,
  output logic      [3:0] wide_wait_bclk,
  output logic      [3:0] half_wait_bclk,
  output logic      [3:0] byte_wait_bclk,
  output logic      [1:0] bus_clk_select,
  output logic            channel_check_enable,
  output logic            parity_check_enable,
  output logic            speaker_data_bit,
  output logic            timer_two_gate
);

  // One-hot select of the indexed register; zero for foreign indexes
  function automatic cir_sel_t cir_sel_f(input logic [7:0] idx);
    cir_sel_f = {idx == `CIR_IDX_WAIT_CLK, idx == `CIR_IDX_CMD_DELAY,
                 idx == `CIR_IDX_CLK_NMI};
  endfunction : cir_sel_f

  // Wait-state code to bus clocks: (base - code) waits of two clocks
  function automatic logic [3:0] cir_wait_bclk_f(input logic [1:0] code,
                                                 input logic [3:0] base);
    cir_wait_bclk_f = 4'((base - {2'h0, code}) << 1);
  endfunction : cir_wait_bclk_f

  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic       idx_vld_r;
  logic       idx_vld_nxt;
  logic [2:0] clk_nmi_r;
  logic [2:0] clk_nmi_nxt;
  logic [7:0] cmd_dly_r;
  logic [7:0] cmd_dly_nxt;
  logic [7:0] wait_clk_r;
  logic [7:0] wait_clk_nxt;
  logic [3:0] portb_r;
  logic [3:0] portb_nxt;
  logic       pf_flag_r;
  logic       pf_flag_nxt;
  logic       to_flag_r;
  logic       to_flag_nxt;
  logic       nmi_r;
  logic       nmi_nxt;
  logic       pf_prev_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvld_r;
  logic       rvld_nxt;
  logic       wd_timeout;
  logic       idx_wr;
  logic       data_acc;
  logic       data_wr;
  logic       data_rd;
  cir_sel_t   sel;
  logic       portb_wr;
  logic       portb_rd;
  logic       arb;
  logic [7:0] reg04_view;

  // Ready watchdog for cycles claimed by the local bus
  cir_ready_watchdog u_watchdog
  (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .cycle_start_strobe (cycle_start_strobe),
    .local_bus_claim    (local_bus_claim),
    .ready_in           (ready_in),
    .timeout_pulse      (wd_timeout)
  );

  // Port decode; a data access only counts while a fresh index is held
  assign idx_wr   = io_wr && (io_addr == `CIR_INDEX_PORT);                      // R1
  assign data_acc = (io_wr || io_rd) && (io_addr == `CIR_DATA_PORT);
  assign data_wr  = io_wr && (io_addr == `CIR_DATA_PORT) && idx_vld_r;          // R3
  assign data_rd  = io_rd && (io_addr == `CIR_DATA_PORT) && idx_vld_r;          // R3
  assign sel      = cir_sel_f(idx_r);
  assign portb_wr = speaker_port_select && peripheral_io_write;                 // R23
  assign portb_rd = speaker_port_select && peripheral_io_read;                  // R23

  // NMI arbitration on an enabled power-fail edge or an enabled timeout
  assign arb = (clk_nmi_r[`CIR_B_PF_EN - `CIR_B_TO_EN] && power_fail_input && !pf_prev_r) // R10
            || (clk_nmi_r[`CIR_B_TO_EN - 2] && wd_timeout);                     // R11

  // Read view of index 04H; bit 5 reads zero
  assign reg04_view = {`CIR_VERSION, 1'b0, clk_nmi_r, pf_flag_r, to_flag_r};    // R7 R24

  // Index holder: loaded by the index port, consumed by any data access
  always_comb
  begin
    idx_nxt     = idx_r;
    idx_vld_nxt = idx_vld_r;
    if (idx_wr)
    begin
      idx_nxt     = io_wdata;                                                   // R1
      idx_vld_nxt = 1'b1;
    end
    else if (data_acc || cpu_warm_rst)
      idx_vld_nxt = 1'b0;                                                       // R3
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idx_r     <= 8'h00;
      idx_vld_r <= 1'b0;
    end
    else
    begin
      idx_r     <= idx_nxt;
      idx_vld_r <= idx_vld_nxt;
    end
  end

  // Configuration registers; warm reset leaves them alone
  always_comb
  begin
    clk_nmi_nxt  = clk_nmi_r;
    cmd_dly_nxt  = cmd_dly_r;
    wait_clk_nxt = wait_clk_r;
    portb_nxt    = portb_r;
    if (data_wr && sel[0])
      clk_nmi_nxt = io_wdata[`CIR_B_PROC_CLK:`CIR_B_TO_EN];                     // R8 R10 R11
    if (data_wr && sel[1])
      cmd_dly_nxt = io_wdata;                                                   // R15
    if (data_wr && sel[2])
    begin
      wait_clk_nxt[7:2] = io_wdata[7:2];                                        // R19 R20 R21
      if (io_wdata[1:0] != `CIR_BCLK_RESERVED)
        wait_clk_nxt[1:0] = io_wdata[1:0];                                      // R22 R24
    end
    if (portb_wr)
      portb_nxt = io_wdata[3:0];                                                // R4 R5 R6
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clk_nmi_r  <= `CIR_RST_CLK_NMI;                                           // R25
      cmd_dly_r  <= `CIR_RST_CMD_DELAY;                                         // R16 R17
      wait_clk_r <= `CIR_RST_WAIT_CLK;                                          // R19 R20 R21
      portb_r    <= `CIR_RST_PORTB;
    end
    else
    begin
      clk_nmi_r  <= clk_nmi_nxt;
      cmd_dly_r  <= cmd_dly_nxt;
      wait_clk_r <= wait_clk_nxt;
      portb_r    <= portb_nxt;
    end
  end

  // Status flags and NMI; a timeout landing on the clearing read still sets
  always_comb
  begin
    pf_flag_nxt = arb ? power_fail_input : pf_flag_r;                           // R12
    to_flag_nxt = to_flag_r;
    if (data_rd && sel[0])
      to_flag_nxt = 1'b0;
    if (wd_timeout)
      to_flag_nxt = 1'b1;                                                       // R13
    nmi_nxt = arb;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pf_flag_r <= 1'b0;
      to_flag_r <= 1'b0;
      nmi_r     <= 1'b0;
      pf_prev_r <= 1'b0;
    end
    else
    begin
      pf_flag_r <= pf_flag_nxt;
      to_flag_r <= to_flag_nxt;
      nmi_r     <= nmi_nxt;
      pf_prev_r <= power_fail_input;
    end
  end

  // Read answers from the data port and from Port B
  always_comb
  begin
    rdata_nxt = rdata_r;
    rvld_nxt  = 1'b0;
    if (data_rd && (sel != 3'h0))
    begin
      rvld_nxt = 1'b1;
      case (sel)
        3'h1:    rdata_nxt = reg04_view;
        3'h2:    rdata_nxt = cmd_dly_r;
        3'h4:    rdata_nxt = wait_clk_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    else if (portb_rd)
    begin
      rvld_nxt  = 1'b1;
      rdata_nxt = {parity_error_status, channel_error_status,                  // R23
                   timer_two_output_status, refresh_detect_status, portb_r};   // R4
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_r <= 8'h00;
      rvld_r  <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvld_r  <= rvld_nxt;
    end
  end

  // Outputs; command delays count half expansion-clock steps
  assign io_rdata                 = rdata_r;
  assign io_rdata_valid           = rvld_r;
  assign proc_clock_select        = clk_nmi_r[2];                               // R8
  assign power_fail_nmi_enable    = clk_nmi_r[1];
  assign ready_timeout_nmi_enable = clk_nmi_r[0];
  assign power_fail_seen_flag     = pf_flag_r;
  assign ready_timeout_flag       = to_flag_r;
  assign nmi_out                  = nmi_r;
  assign wide_mem_cmd_delay       = cmd_dly_r[7:6];                             // R16 R18
  assign half_mem_cmd_delay       = cmd_dly_r[5:4];
  assign byte_mem_cmd_delay       = cmd_dly_r[3:2];                             // R17 R18
  assign io_cmd_delay             = cmd_dly_r[1:0];
  assign wide_wait_bclk = cir_wait_bclk_f(wait_clk_r[7:6], `CIR_WAIT_BASE_WIDE); // R19
  assign half_wait_bclk = cir_wait_bclk_f(wait_clk_r[5:4], `CIR_WAIT_BASE_WIDE); // R20
  assign byte_wait_bclk = cir_wait_bclk_f(wait_clk_r[3:2], `CIR_WAIT_BASE_BYTE); // R21
  assign bus_clk_select           = wait_clk_r[1:0];                            // R22
  assign channel_check_enable     = portb_r[3];                                 // R5
  assign parity_check_enable      = portb_r[2];
  assign speaker_data_bit         = portb_r[1];                                 // R6
  assign timer_two_gate           = portb_r[0];

  // Index capture
  a_index_capture: assert property (@(posedge clk) disable iff (sys_rst) // R1
    idx_wr |=> idx_vld_r && idx_r == $past(io_wdata))
    else $error("index not captured");

  // Data access consumes the index
  a_index_consumed: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (data_acc && !idx_wr) |=> !idx_vld_r)
    else $error("index survived a data access");

  // Stale data read gives no answer
  a_stale_silent: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (io_rd && io_addr == `CIR_DATA_PORT && !idx_vld_r && !portb_rd) |=> !io_rdata_valid)
    else $error("stale read answered");

  // Port B read returns live status in bits 7 and 5
  a_portb_status: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (portb_rd && !data_rd) |=> io_rdata_valid
      && io_rdata[5] == $past(timer_two_output_status)
      && io_rdata[7] == $past(parity_error_status))
    else $error("port B status wrong");

  // Port B write reaches the four control outputs
  a_portb_write: assert property (@(posedge clk) disable iff (sys_rst) // R6
    portb_wr |=> {channel_check_enable, parity_check_enable, speaker_data_bit,
                  timer_two_gate} == $past(io_wdata[3:0]))
    else $error("port B write lost");

  // Reserved bus clock code is ignored
  a_reserved_clock: assert property (@(posedge clk) disable iff (sys_rst) // R24
    (data_wr && sel[2] && io_wdata[1:0] == `CIR_BCLK_RESERVED)
      |=> bus_clk_select == $past(bus_clk_select) && bus_clk_select != `CIR_BCLK_RESERVED)
    else $error("reserved clock code taken");

  // Byte wait code maps to twice (5 - code) bus clocks
  a_byte_waits: assert property (@(posedge clk) disable iff (sys_rst) // R21
    (data_wr && sel[2]) |=> byte_wait_bclk == 4'((4'h5 - {2'h0, $past(io_wdata[3:2])}) * 2))
    else $error("byte wait decode wrong");

  // Enabled timeout raises NMI and flag next cycle
  a_timeout_nmi: assert property (@(posedge clk) disable iff (sys_rst) // R11
    (wd_timeout && ready_timeout_nmi_enable) |=> nmi_out && ready_timeout_flag)
    else $error("timeout NMI missing");

  // Power-fail seen flag follows the pin at arbitration
  a_pf_capture: assert property (@(posedge clk) disable iff (sys_rst) // R12
    arb |=> nmi_out && power_fail_seen_flag == $past(power_fail_input))
    else $error("power-fail flag wrong");

  // Warm reset leaves configuration untouched
  a_warm_keep: assert property (@(posedge clk) disable iff (sys_rst) // R25
    (cpu_warm_rst && !data_wr && !portb_wr) |=> $stable(cmd_dly_r) && $stable(wait_clk_r)
      && $stable(clk_nmi_r))
    else $error("warm reset changed configuration");

  c_reg04_read: cover property (@(posedge clk) disable iff (sys_rst) data_rd && sel[0]);
  c_portb_write: cover property (@(posedge clk) disable iff (sys_rst) portb_wr);
  c_nmi_raised: cover property (@(posedge clk) disable iff (sys_rst) nmi_out);
  c_stale_access: cover property (@(posedge clk) disable iff (sys_rst)
    data_acc && !idx_vld_r);

endmodule : cir_config_index_regs

// File: cir_map.svh
`ifndef CIR_MAP_SVH
`define CIR_MAP_SVH

// I/O port addresses of the index and data ports
`define CIR_INDEX_PORT      16'h0022
`define CIR_DATA_PORT       16'h0023

// Indexes of the configuration registers
`define CIR_IDX_CLK_NMI     8'h04
`define CIR_IDX_CMD_DELAY   8'h05
`define CIR_IDX_WAIT_CLK    8'h06

// Field positions, index 04H
`define CIR_B_VERSION_HI    7
`define CIR_B_VERSION_LO    6
`define CIR_B_PROC_CLK      4
`define CIR_B_PF_EN         3
`define CIR_B_TO_EN         2
`define CIR_B_PF_FLAG       1
`define CIR_B_TO_FLAG       0

// Version field value, arbitrary
`define CIR_VERSION         2'h1

// Reset values
`define CIR_RST_CLK_NMI     3'h0
`define CIR_RST_CMD_DELAY   8'h05
`define CIR_RST_WAIT_CLK    8'h00
`define CIR_RST_PORTB       4'h0

// Wait-state base counts (code 0 value) and bus-clock codes
`define CIR_WAIT_BASE_WIDE  4'h3
`define CIR_WAIT_BASE_BYTE  4'h5
`define CIR_BCLK_RESERVED   2'h2

// Ready timeout, in fast-clock cycles
`define CIR_RDY_TIMEOUT_CYC 128
`define CIR_RDY_LAST        7'(`CIR_RDY_TIMEOUT_CYC - 1)

`endif

// File: cir_pkg.sv
package cir_pkg;

  // Ready watchdog states
  typedef enum logic [1:0]
  {
    CIR_WD_IDLE,
    CIR_WD_SAMPLE,
    CIR_WD_WAIT
  } cir_wd_state_t;

  // One-hot register select
  typedef logic [2:0] cir_sel_t;

endpackage : cir_pkg

// File: cir_ready_watchdog.sv
`timescale 1ns/100ps
`include "cir_map.svh"

module cir_ready_watchdog
  import cir_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic cycle_start_strobe,
  input  wire logic local_bus_claim,
  input  wire logic ready_in,
  output logic      timeout_pulse
);

  cir_wd_state_t state_r;
  cir_wd_state_t state_nxt;
  logic [6:0]    cnt_r;
  logic [6:0]    cnt_nxt;
  logic          pulse_r;
  logic          pulse_nxt;

  // Claim is sampled one cycle after the cycle start, then ready is awaited
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    pulse_nxt = 1'b0;
    case (state_r)
      CIR_WD_IDLE:
      begin
        if (cycle_start_strobe)
          state_nxt = CIR_WD_SAMPLE;
      end
      CIR_WD_SAMPLE:
      begin
        cnt_nxt   = 7'h00;
        state_nxt = (local_bus_claim && !ready_in) ? CIR_WD_WAIT : CIR_WD_IDLE;
      end
      CIR_WD_WAIT:
      begin
        if (ready_in)
          state_nxt = CIR_WD_IDLE;
        else if (cnt_r == `CIR_RDY_LAST)
        begin
          pulse_nxt = 1'b1; // R14
          state_nxt = CIR_WD_IDLE;
        end
        else
          cnt_nxt = cnt_r + 7'h01;
      end
      default:
        state_nxt = CIR_WD_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= CIR_WD_IDLE;
      cnt_r   <= 7'h00;
      pulse_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign timeout_pulse = pulse_r;

  // Timeout only after the full count without ready
  a_timeout_full_count: assert property (@(posedge clk) disable iff (sys_rst) // R14
    pulse_r |-> $past(cnt_r) == `CIR_RDY_LAST && !$past(ready_in))
    else $error("timeout raised before full count");

  // Ready during the wait ends it quietly
  a_ready_ends_wait: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (state_r == CIR_WD_WAIT && ready_in) |=> state_r == CIR_WD_IDLE && !pulse_r)
    else $error("ready did not end the wait");

  c_timeout_seen: cover property (@(posedge clk) disable iff (sys_rst) pulse_r);

endmodule : cir_ready_watchdog

// File: config_index_regs_test.sv
`timescale 1ns/100ps
`include "cir_map.svh"

module config_index_regs_test
  import cir_pkg::*;
  ();

  localparam logic [1:0] VER = `CIR_VERSION;

  logic       clk, sys_rst, cpu_warm_rst, io_wr, io_rd, io_rdata_valid;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic       speaker_port_select, peripheral_io_read, peripheral_io_write;
  logic       cycle_start_strobe, local_bus_claim, ready_in, power_fail_input;
  logic       timer_two_output_status, refresh_detect_status;
  logic       parity_error_status, channel_error_status;
  logic       proc_clock_select, power_fail_nmi_enable, ready_timeout_nmi_enable;
  logic       power_fail_seen_flag, ready_timeout_flag, nmi_out;
  logic [1:0] wide_mem_cmd_delay, half_mem_cmd_delay, byte_mem_cmd_delay;
  logic [1:0] io_cmd_delay, bus_clk_select;
  logic [3:0] wide_wait_bclk, half_wait_bclk, byte_wait_bclk;
  logic       channel_check_enable, parity_check_enable;
  logic       speaker_data_bit, timer_two_gate;
  int         n_mismatch, tests_run, nmi_count;

  cir_config_index_regs DUT
  (
    .clk, .sys_rst, .cpu_warm_rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .io_rdata_valid, .speaker_port_select, .peripheral_io_read, .peripheral_io_write,
    .cycle_start_strobe, .local_bus_claim, .ready_in, .power_fail_input,
    .timer_two_output_status, .refresh_detect_status, .parity_error_status,
    .channel_error_status, .proc_clock_select, .power_fail_nmi_enable,
    .ready_timeout_nmi_enable, .power_fail_seen_flag, .ready_timeout_flag, .nmi_out,
    .wide_mem_cmd_delay, .half_mem_cmd_delay, .byte_mem_cmd_delay, .io_cmd_delay,
    .wide_wait_bclk, .half_wait_bclk, .byte_wait_bclk, .bus_clk_select,
    .channel_check_enable, .parity_check_enable, .speaker_data_bit, .timer_two_gate
  );

  // Clock, 50 ns period
  always #25 clk = ~clk;

  // Counts NMI pulses
  always @(posedge clk)
    if (nmi_out === 1'b1)
      nmi_count <= nmi_count + 1;

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // One I/O access, strobe held for one edge
  task automatic io_op(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk);
    io_addr = addr;
    io_wdata = data;
    io_wr = wr;
    io_rd = !wr;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io_op

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
    io_op(1'b1, `CIR_INDEX_PORT, idx);
    io_op(1'b1, `CIR_DATA_PORT, data);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    io_op(1'b1, `CIR_INDEX_PORT, idx);
    io_op(1'b0, `CIR_DATA_PORT, 8'h00);
    // Valid stands for one cycle, right after the read edge
    check("rd_valid", 8'h01, {7'h00, io_rdata_valid});
    check("rd_data", exp, io_rdata);
  endtask : reg_rd

  // Data-port read that must not be answered
  task automatic stale_rd();
    io_op(1'b0, `CIR_DATA_PORT, 8'h00);
    check("stale_valid", 8'h00, {7'h00, io_rdata_valid});
  endtask : stale_rd

  // Port B access through the chip-select
  task automatic pb_op(input logic wr, input logic sel, input logic [7:0] data);
    @(negedge clk);
    speaker_port_select = sel;
    peripheral_io_write = wr;
    peripheral_io_read = !wr;
    io_wdata = data;
    @(negedge clk);
    peripheral_io_write = 1'b0;
    peripheral_io_read = 1'b0;
    speaker_port_select = 1'b0;
  endtask : pb_op

  // Start of a local-bus claimed cycle, ready low
  task automatic start_cycle();
    @(negedge clk);
    cycle_start_strobe = 1'b1;
    @(negedge clk);
    cycle_start_strobe = 1'b0;
    local_bus_claim = 1'b1;
    @(negedge clk);
    local_bus_claim = 1'b0;
  endtask : start_cycle

  // Defaults after full reset
  task automatic t_reset();
    check("dly", 8'h05, {wide_mem_cmd_delay, half_mem_cmd_delay, byte_mem_cmd_delay,
                         io_cmd_delay});
    check("wwide", 8'h06, {4'h0, wide_wait_bclk});
    check("whalf", 8'h06, {4'h0, half_wait_bclk});
    check("wbyte", 8'h0A, {4'h0, byte_wait_bclk});
    reg_rd(`CIR_IDX_CLK_NMI, {VER, 6'h00});
    reg_rd(`CIR_IDX_CMD_DELAY, 8'h05);
    reg_rd(`CIR_IDX_WAIT_CLK, 8'h00);
  endtask : t_reset

  // Delay fields and every wait code
  task automatic t_fields();
    reg_wr(`CIR_IDX_CMD_DELAY, 8'hE4);
    check("dly", 8'hE4, {wide_mem_cmd_delay, half_mem_cmd_delay, byte_mem_cmd_delay,
                         io_cmd_delay});
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(`CIR_IDX_WAIT_CLK, {c[1:0], c[1:0], c[1:0], 2'h1});
      check("wwide", 8'((3 - c) * 2), {4'h0, wide_wait_bclk});
      check("whalf", 8'((3 - c) * 2), {4'h0, half_wait_bclk});
      check("wbyte", 8'((5 - c) * 2), {4'h0, byte_wait_bclk});
      check("bclk", 8'h01, {6'h00, bus_clk_select});
    end
    reg_wr(`CIR_IDX_WAIT_CLK, 8'h03);
    reg_wr(`CIR_IDX_WAIT_CLK, 8'h02);
    check("bclk_rsv", 8'h03, {6'h00, bus_clk_select});
    reg_rd(`CIR_IDX_WAIT_CLK, 8'h03);
  endtask : t_fields

  // Writable and read-only bits of index 04H
  task automatic t_ctrl();
    reg_wr(`CIR_IDX_CLK_NMI, 8'hFF);
    check("en_on", 8'h07, {5'h00, proc_clock_select, power_fail_nmi_enable,
                           ready_timeout_nmi_enable});
    check("flags", 8'h00, {6'h00, power_fail_seen_flag, ready_timeout_flag});
    reg_rd(`CIR_IDX_CLK_NMI, {VER, 6'h1C});
    reg_wr(`CIR_IDX_CLK_NMI, 8'h00);
    check("en", 8'h00, {proc_clock_select, power_fail_nmi_enable,
                        ready_timeout_nmi_enable});
  endtask : t_ctrl

  // Index consumed by a data read and by warm reset; stale and foreign accesses ignored
  task automatic t_stale();
    reg_rd(`CIR_IDX_CMD_DELAY, 8'hE4);
    stale_rd();
    io_op(1'b1, `CIR_DATA_PORT, 8'h00);
    check("dly_keep", 8'hE4, {wide_mem_cmd_delay, half_mem_cmd_delay, byte_mem_cmd_delay,
                              io_cmd_delay});
    io_op(1'b1, `CIR_INDEX_PORT, 8'h07);
    stale_rd();
    io_op(1'b1, `CIR_INDEX_PORT, `CIR_IDX_CMD_DELAY);
    @(negedge clk);
    cpu_warm_rst = 1'b1;
    @(negedge clk);
    cpu_warm_rst = 1'b0;
    io_op(1'b1, `CIR_DATA_PORT, 8'h00);
    check("warm", 8'hE4, {wide_mem_cmd_delay, half_mem_cmd_delay, byte_mem_cmd_delay,
                          io_cmd_delay});
  endtask : t_stale

  // Port B control and status bits
  task automatic t_portb();
    parity_error_status = 1'b1;
    timer_two_output_status = 1'b1;
    pb_op(1'b1, 1'b1, 8'hFF);
    check("pb_ctrl", 8'h0F, {channel_check_enable, parity_check_enable,
                             speaker_data_bit, timer_two_gate});
    pb_op(1'b1, 1'b0, 8'h00);
    check("pb_nosel", 8'h0F, {channel_check_enable, parity_check_enable,
                              speaker_data_bit, timer_two_gate});
    pb_op(1'b0, 1'b1, 8'h00);
    check("pb_valid", 8'h01, {7'h00, io_rdata_valid});
    check("pb_rd", 8'hAF, io_rdata);
    pb_op(1'b1, 1'b1, 8'hF0);
    pb_op(1'b0, 1'b1, 8'h00);
    check("pb_rd2", 8'hA0, io_rdata);
  endtask : t_portb

  // Ready watchdog, abort and expiry
  task automatic t_timeout();
    int base;
    reg_wr(`CIR_IDX_CLK_NMI, 8'h04);
    base = nmi_count;
    start_cycle();
    repeat (5) @(negedge clk);
    ready_in = 1'b1;
    @(negedge clk);
    ready_in = 1'b0;
    repeat (140) @(negedge clk);
    check("to_abort", 8'h00, {7'h00, ready_timeout_flag});
    start_cycle();
    repeat (128) @(negedge clk);
    check("to_early", 8'h00, {7'h00, ready_timeout_flag});
    @(negedge clk);
    check("to_flag", 8'h01, {7'h00, ready_timeout_flag});
    check("to_pulse", 8'h01, {7'h00, nmi_out});
    @(negedge clk);
    check("to_nmi", 8'(base + 1), nmi_count[7:0]);
    reg_rd(`CIR_IDX_CLK_NMI, {VER, 6'h05});
    reg_wr(`CIR_IDX_CLK_NMI, 8'h00);
    start_cycle();
    repeat (140) @(negedge clk);
    check("to_flag2", 8'h01, {7'h00, ready_timeout_flag});
    check("to_nonmi", 8'(base + 1), nmi_count[7:0]);
  endtask : t_timeout

  // Power-fail warning NMI
  task automatic t_power_fail_input();
    int base;
    base = nmi_count;
    power_fail_input = 1'b1;
    repeat (3) @(negedge clk);
    check("pf_off", 8'(base), nmi_count[7:0]);
    power_fail_input = 1'b0;
    reg_wr(`CIR_IDX_CLK_NMI, 8'h08);
    power_fail_input = 1'b1;
    repeat (3) @(negedge clk);
    check("pf_nmi", 8'(base + 1), nmi_count[7:0]);
    check("pf_flag", 8'h01, {7'h00, power_fail_seen_flag});
    power_fail_input = 1'b0;
  endtask : t_power_fail_input

  // Watchdog on the whole run
  initial
  begin
    #2000000;
    n_mismatch++;
    test_done();
  end

  // Main sequence
  initial
  begin
    {clk, cpu_warm_rst, io_addr, io_wr, io_rd, io_wdata} = '0;
    {speaker_port_select, peripheral_io_read, peripheral_io_write} = '0;
    {cycle_start_strobe, local_bus_claim, ready_in, power_fail_input} = '0;
    {timer_two_output_status, refresh_detect_status} = '0;
    {parity_error_status, channel_error_status} = '0;
    n_mismatch = 0;
    tests_run = 0;
    nmi_count = 0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_ctrl();
    t_stale();
    t_portb();
    t_timeout();
    t_power_fail_input();
    test_done();
  end

endmodule : config_index_regs_test
